// [shared/cra_pkg.sv]
// Shared constants for the configuration-message register access link
package cra_pkg;
  // ----------
  // Link tokens
  // ----------
  localparam logic [7:0] CRA_TOK_WRITE = 8'hC0;
  localparam logic [7:0] CRA_TOK_READ = 8'hC1;
  localparam logic [7:0] CRA_TOK_END = 8'h01;
  localparam logic [7:0] CRA_TOK_ACK = 8'h03;
  localparam logic [7:0] CRA_TOK_NACK = 8'h04;
  localparam logic [7:0] CRA_NO_REPLY = 8'hFF;
  localparam int CRA_RET_BYTES = 3;
  localparam int CRA_REG_BYTES = 2;
  localparam int CRA_DATA_BYTES = 4;
  // ----------
  // Destinations
  // ----------
  localparam logic [15:0] CRA_DEST_TILE = 16'hC20C;
  localparam logic [15:0] CRA_DEST_NODE = 16'hC30C;
  // ----------
  // Processor-status bank
  // ----------
  localparam logic [7:0] CRA_PS_RES_TYPE = 8'h0C;
  localparam logic [7:0] CRA_PS_RAM_BASE = 8'h00;
  localparam logic [7:0] CRA_PS_VEC_BASE = 8'h01;
  localparam logic [7:0] CRA_PS_TILE_CTRL = 8'h02;
  localparam logic [31:0] CRA_RAM_BASE_RST = 32'h00010000;
  localparam logic [31:0] CRA_RAM_BASE_MASK = 32'hFFFFFFFC;
  localparam logic [31:0] CRA_VEC_BASE_MASK = 32'hFFFF0000;
  localparam logic [31:0] CRA_TILE_CTRL_MASK = 32'h00000030;
  localparam int CRA_CLK_DIV_EN_BIT = 4;
  localparam int CRA_CLK_DIV_DYN_BIT = 5;
  // ----------
  // Request FIFO entry: {dest, ctrl, byte}
  // ----------
  localparam int CRA_TOK_W = 41;
  localparam int CRA_FIFO_DEPTH = 16;
endpackage : cra_pkg

// [shared/cra_link_if.sv]
// Token link between the requester and the configuration access end
`timescale 1ns/1ps
interface cra_link_if;
  logic req_valid;
  logic req_ready;
  logic req_ctrl;
  logic [7:0] req_data;
  logic [31:0] req_dest;
  logic rsp_valid;
  logic rsp_ready;
  logic rsp_ctrl;
  logic [7:0] rsp_data;
  logic [23:0] rsp_dest;

  modport dev (
    input req_valid, req_ctrl, req_data, req_dest, rsp_ready,
    output req_ready, rsp_valid, rsp_ctrl, rsp_data, rsp_dest
  );
  modport host (
    output req_valid, req_ctrl, req_data, req_dest, rsp_ready,
    input req_ready, rsp_valid, rsp_ctrl, rsp_data, rsp_dest
  );
endinterface : cra_link_if

// [logic/cra_device.sv]
// Configuration access end: request FIFO, message decoder and register banks
//
// Overview of operation
// - Three banks: tile and node share the link path, status has its own port
// - Requests carry a 24-bit return address
// - Write with low byte FF gets no reply
// - Multi-byte fields travel most significant first
// - Status resource id is number<<8 OR 0x0C
// - Status access moves one full 32-bit word
// - Tile bank destination low half is C20C
// - Node bank destination low half is C30C
// - Write: 192, return, register, data, 1
// - Write reply: 3,1 success; 4,1 failure
// - Read: 193, return, register, 1
// - Read reply: 3,data,1 or 4,1
// - Status numbers decode to tile status map
`timescale 1ns/1ps

// ----------
// Token FIFO
// ----------
module cra_fifo #(
  parameter int WIDTH = 41,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire empty = (wr_ptr == rd_ptr);
  wire push = in_valid_i && !full;
  wire pop = out_ready_i && !empty;

  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // Storage needs no reset; only entries behind the write pointer are read
  always_ff @(posedge sys_clk_i) begin
    if (push) mem[wr_ptr[AW-1:0]] <= in_data_i;
  end
endmodule : cra_fifo

// ----------
// Device end
// ----------
module cra_device import cra_pkg::*; #(
  parameter logic [15:0] OWN_ID = 16'h0001, // Arbitrary default
  parameter int TILE_REGS = 8,
  parameter int NODE_REGS = 8
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  cra_link_if.dev link,
  input wire logic ps_valid_i,
  input wire logic ps_write_i,
  input wire logic [31:0] ps_res_i,
  input wire logic [31:0] ps_wdata_i,
  output logic ps_done_o,
  output logic ps_ok_o,
  output logic [31:0] ps_rdata_o,
  output logic clk_div_en_o,
  output logic clk_div_dyn_o,
  output logic [TILE_REGS*32-1:0] tile_cfg_o,
  output logic [NODE_REGS*32-1:0] node_cfg_o
);
  localparam int TW = $clog2(TILE_REGS);
  localparam int NW = $clog2(NODE_REGS);

  typedef enum logic [3:0] {
    ST_CMD, ST_RET, ST_REG, ST_DATA, ST_END, ST_SKIP, ST_HEAD, ST_BODY,
    ST_TAIL
  } cra_dev_state_t;

  cra_dev_state_t state;
  logic is_wr;
  logic bank_node;
  logic bad;
  logic ok;
  logic [1:0] cnt;
  logic [23:0] ret;
  logic [15:0] regn;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [31:0] tile_q [TILE_REGS];
  logic [31:0] node_q [NODE_REGS];
  logic [31:0] ram_base;
  logic [31:0] vec_base;
  logic [31:0] tile_ctrl;

  // ----------
  // Request buffering
  // ----------
  logic fifo_valid;
  logic [CRA_TOK_W-1:0] fifo_data;
  wire parsing = (state != ST_HEAD) && (state != ST_BODY) &&
                 (state != ST_TAIL);

  cra_fifo #(.WIDTH(CRA_TOK_W), .DEPTH(CRA_FIFO_DEPTH)) u_fifo (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(link.req_valid),
    .in_ready_o(link.req_ready),
    .in_data_i({link.req_dest, link.req_ctrl, link.req_data}),
    .out_valid_o(fifo_valid),
    .out_ready_i(parsing),
    .out_data_o(fifo_data)
  );

  // ----------
  // Decode
  // ----------
  wire pop = fifo_valid && parsing;
  wire [31:0] tok_dest = fifo_data[40:9];
  wire tok_ctrl = fifo_data[8];
  wire [7:0] tok_byte = fifo_data[7:0];
  wire is_cmd = tok_ctrl && (tok_byte == CRA_TOK_WRITE ||
                             tok_byte == CRA_TOK_READ);
  wire is_end = tok_ctrl && (tok_byte == CRA_TOK_END);
  wire dest_tile = tok_dest[15:0] == CRA_DEST_TILE;
  wire dest_node = tok_dest[15:0] == CRA_DEST_NODE;
  wire dest_bad = (tok_dest[31:16] != OWN_ID) || !(dest_tile || dest_node);
  wire in_field = (state == ST_RET) || (state == ST_REG) ||
                  (state == ST_DATA);
  wire [1:0] field_last = (state == ST_RET) ? 2'(CRA_RET_BYTES - 1) :
                          (state == ST_REG) ? 2'(CRA_REG_BYTES - 1) :
                          2'(CRA_DATA_BYTES - 1);
  wire tile_hit = {16'h0000, regn} < TILE_REGS;
  wire node_hit = {16'h0000, regn} < NODE_REGS;
  wire reg_hit = bank_node ? node_hit : tile_hit;
  wire fin = pop && is_end && (in_field || state == ST_SKIP ||
                               state == ST_END);
  wire fin_ok = (state == ST_END) && !bad && reg_hit;
  wire do_write = fin && fin_ok && is_wr;
  wire [31:0] sel_rd = bank_node ? node_q[regn[NW-1:0]] :
                                   tile_q[regn[TW-1:0]];
  wire quiet = is_wr && (ret[7:0] == CRA_NO_REPLY);
  wire [1:0] body_sel = 2'(CRA_DATA_BYTES - 1) - cnt;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= ST_CMD;
      is_wr <= 1'b0;
      bank_node <= 1'b0;
      bad <= 1'b0;
      ok <= 1'b0;
      cnt <= 2'h0;
      ret <= 24'h000000;
      regn <= 16'h0000;
      wdat <= 32'h00000000;
      rdat <= 32'h00000000;
    end else begin
      unique case (state)
        ST_CMD: begin
          // Tokens outside a message have no return path and are dropped
          if (pop && is_cmd) begin
            is_wr <= (tok_byte == CRA_TOK_WRITE);
            bank_node <= dest_node;
            bad <= dest_bad;
            cnt <= 2'h0;
            state <= ST_RET;
          end
        end
        ST_RET, ST_REG, ST_DATA: begin
          if (pop && tok_ctrl && !is_end) begin
            state <= ST_SKIP;
          end else if (pop && !tok_ctrl) begin
            if (state == ST_RET) ret <= {ret[15:0], tok_byte};
            if (state == ST_REG) regn <= {regn[7:0], tok_byte};
            if (state == ST_DATA) wdat <= {wdat[23:0], tok_byte};
            cnt <= cnt + 2'h1;
            if (cnt == field_last) begin
              cnt <= 2'h0;
              if (state == ST_RET) state <= ST_REG;
              else if (state == ST_REG && is_wr) state <= ST_DATA;
              else state <= ST_END;
            end
          end
        end
        ST_END: begin
          if (pop && !is_end) state <= ST_SKIP;
        end
        ST_SKIP: ;
        ST_HEAD: begin
          if (link.rsp_ready) begin
            state <= (ok && !is_wr) ? ST_BODY : ST_TAIL;
          end
        end
        ST_BODY: begin
          if (link.rsp_ready) begin
            cnt <= cnt + 2'h1;
            if (cnt == 2'(CRA_DATA_BYTES - 1)) state <= ST_TAIL;
          end
        end
        ST_TAIL: begin
          if (link.rsp_ready) state <= ST_CMD;
        end
      endcase
      if (fin) begin
        ok <= fin_ok;
        rdat <= sel_rd;
        cnt <= 2'h0;
        state <= quiet ? ST_CMD : ST_HEAD;
      end
    end
  end

  // ----------
  // Reply
  // ----------
  assign link.rsp_valid = (state == ST_HEAD) || (state == ST_BODY) ||
                          (state == ST_TAIL);
  assign link.rsp_ctrl = (state != ST_BODY);
  assign link.rsp_data = (state == ST_HEAD) ?
                         (ok ? CRA_TOK_ACK : CRA_TOK_NACK) :
                         (state == ST_BODY) ? rdat[8*body_sel+:8] :
                         CRA_TOK_END;
  assign link.rsp_dest = ret;

  // ----------
  // Configuration banks
  // ----------
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < TILE_REGS; i++) tile_q[i] <= 32'h00000000;
      for (int i = 0; i < NODE_REGS; i++) node_q[i] <= 32'h00000000;
    end else if (do_write) begin
      if (bank_node) node_q[regn[NW-1:0]] <= wdat;
      else tile_q[regn[TW-1:0]] <= wdat;
    end
  end

  for (genvar g = 0; g < TILE_REGS; g++) begin : g_tile
    assign tile_cfg_o[32*g+:32] = tile_q[g];
  end
  for (genvar g = 0; g < NODE_REGS; g++) begin : g_node
    assign node_cfg_o[32*g+:32] = node_q[g];
  end

  // ----------
  // Processor-status bank, reached directly by resource id
  // ----------
  wire [7:0] ps_num = ps_res_i[15:8];
  wire ps_res_ok = (ps_res_i[7:0] == CRA_PS_RES_TYPE) &&
                   (ps_res_i[31:16] == 16'h0000);
  wire ps_hit = ps_res_ok && (ps_num == CRA_PS_RAM_BASE ||
                ps_num == CRA_PS_VEC_BASE || ps_num == CRA_PS_TILE_CTRL);
  wire ps_wr = ps_valid_i && ps_write_i && ps_hit;
  wire [31:0] ps_sel = (ps_num == CRA_PS_RAM_BASE) ? ram_base :
                       (ps_num == CRA_PS_VEC_BASE) ? vec_base :
                       (ps_num == CRA_PS_TILE_CTRL) ? tile_ctrl :
                       32'h00000000;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ram_base <= CRA_RAM_BASE_RST;
      vec_base <= 32'h00000000;
      tile_ctrl <= 32'h00000000;
      ps_done_o <= 1'b0;
      ps_ok_o <= 1'b0;
      ps_rdata_o <= 32'h00000000;
    end else begin
      ps_done_o <= ps_valid_i;
      if (ps_valid_i) ps_ok_o <= ps_hit;
      if (ps_valid_i && !ps_write_i) begin
        ps_rdata_o <= ps_hit ? ps_sel : 32'h00000000;
      end
      if (ps_wr && ps_num == CRA_PS_RAM_BASE) begin
        ram_base <= ps_wdata_i & CRA_RAM_BASE_MASK;
      end
      if (ps_wr && ps_num == CRA_PS_VEC_BASE) begin
        vec_base <= ps_wdata_i & CRA_VEC_BASE_MASK;
      end
      if (ps_wr && ps_num == CRA_PS_TILE_CTRL) begin
        tile_ctrl <= ps_wdata_i & CRA_TILE_CTRL_MASK;
      end
    end
  end

  assign clk_div_en_o = tile_ctrl[CRA_CLK_DIV_EN_BIT];
  assign clk_div_dyn_o = tile_ctrl[CRA_CLK_DIV_DYN_BIT];
endmodule : cra_device

// [logic/cra_requester.sv]
// Requester end: builds access messages and collects the replies
`timescale 1ns/1ps
module cra_requester import cra_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  cra_link_if.host link,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic cmd_write_i,
  input wire logic cmd_node_i,
  input wire logic [15:0] cmd_id_i,
  input wire logic [23:0] cmd_ret_i,
  input wire logic [15:0] cmd_reg_i,
  input wire logic [31:0] cmd_wdata_i,
  output logic res_valid_o,
  output logic res_ok_o,
  output logic [31:0] res_rdata_o,
  input wire logic [7:0] ps_num_i,
  output logic [31:0] ps_res_o
);
  typedef enum logic [2:0] {
    H_IDLE, H_SEND, H_HEAD, H_DATA, H_TAIL
  } cra_host_state_t;

  cra_host_state_t state;
  logic is_wr;
  logic node;
  logic [15:0] id;
  logic [23:0] ret;
  logic [15:0] regn;
  logic [31:0] wdat;
  logic [3:0] idx;
  logic [1:0] cnt;
  logic tok_ctrl;
  logic [7:0] tok_byte;

  // ------------------------------------------------------------------------
  // Outgoing token sequence
  // ------------------------------------------------------------------------
  wire [3:0] last_idx = is_wr ? 4'hA : 4'h6;
  wire quiet = is_wr && (ret[7:0] == CRA_NO_REPLY);

  always_comb begin
    tok_ctrl = 1'b0;
    tok_byte = 8'h00;
    unique case (idx)
      4'h0: begin
        tok_ctrl = 1'b1;
        tok_byte = is_wr ? CRA_TOK_WRITE : CRA_TOK_READ;
      end
      4'h1: tok_byte = ret[23:16];
      4'h2: tok_byte = ret[15:8];
      4'h3: tok_byte = ret[7:0];
      4'h4: tok_byte = regn[15:8];
      4'h5: tok_byte = regn[7:0];
      4'h6: begin
        tok_ctrl = !is_wr;
        tok_byte = is_wr ? wdat[31:24] : CRA_TOK_END;
      end
      4'h7: tok_byte = wdat[23:16];
      4'h8: tok_byte = wdat[15:8];
      4'h9: tok_byte = wdat[7:0];
      4'hA: begin
        tok_ctrl = 1'b1;
        tok_byte = CRA_TOK_END;
      end
      default: tok_byte = 8'h00;
    endcase
  end

  assign link.req_valid = (state == H_SEND);
  assign link.req_ctrl = tok_ctrl;
  assign link.req_data = tok_byte;
  assign link.req_dest = {id, node ? CRA_DEST_NODE : CRA_DEST_TILE};
  assign link.rsp_ready = (state == H_HEAD) || (state == H_DATA) ||
                          (state == H_TAIL);
  assign cmd_ready_o = (state == H_IDLE);
  assign ps_res_o = {16'h0000, ps_num_i, CRA_PS_RES_TYPE};

  wire sent = link.req_valid && link.req_ready;
  wire got = link.rsp_valid && link.rsp_ready;

  // ------------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= H_IDLE;
      is_wr <= 1'b0;
      node <= 1'b0;
      id <= 16'h0000;
      ret <= 24'h000000;
      regn <= 16'h0000;
      wdat <= 32'h00000000;
      idx <= 4'h0;
      cnt <= 2'h0;
      res_valid_o <= 1'b0;
      res_ok_o <= 1'b0;
      res_rdata_o <= 32'h00000000;
    end else begin
      res_valid_o <= 1'b0;
      unique case (state)
        H_IDLE: begin
          if (cmd_valid_i) begin
            is_wr <= cmd_write_i;
            node <= cmd_node_i;
            id <= cmd_id_i;
            ret <= cmd_ret_i;
            regn <= cmd_reg_i;
            wdat <= cmd_wdata_i;
            idx <= 4'h0;
            state <= H_SEND;
          end
        end
        H_SEND: begin
          if (sent) begin
            idx <= idx + 4'h1;
            if (idx == last_idx) begin
              // No reply will come, so report success once sent
              res_valid_o <= quiet;
              res_ok_o <= 1'b1;
              state <= quiet ? H_IDLE : H_HEAD;
            end
          end
        end
        H_HEAD: begin
          if (got) begin
            res_ok_o <= link.rsp_ctrl && (link.rsp_data == CRA_TOK_ACK);
            cnt <= 2'h0;
            state <= (link.rsp_ctrl && link.rsp_data == CRA_TOK_ACK &&
                      !is_wr) ? H_DATA : H_TAIL;
          end
        end
        H_DATA: begin
          if (got) begin
            res_rdata_o <= {res_rdata_o[23:0], link.rsp_data};
            cnt <= cnt + 2'h1;
            if (cnt == 2'(CRA_DATA_BYTES - 1)) state <= H_TAIL;
          end
        end
        H_TAIL: begin
          if (got) begin
            res_valid_o <= 1'b1;
            state <= H_IDLE;
          end
        end
      endcase
    end
  end
endmodule : cra_requester

// [test/cra_link_monitor.sv]
// Checker for the token link joining requester and device ends
`timescale 1ns/1ps
module cra_link_monitor import cra_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_ctrl,
  input wire logic [7:0] req_data,
  input wire logic [31:0] req_dest,
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire logic rsp_ctrl,
  input wire logic [7:0] rsp_data,
  input wire logic [23:0] rsp_dest
);
  // ----------
  // Message tracking
  // ----------
  logic [7:0] op;
  logic [3:0] cnt;
  logic [23:0] ret_cap;
  logic [2:0] rsp_bytes;
  logic ack_read;
  wire req_hs = req_valid && req_ready;
  wire rsp_hs = rsp_valid && rsp_ready;
  wire req_end = req_hs && req_ctrl && req_data == CRA_TOK_END;
  wire quiet = op == CRA_TOK_WRITE && ret_cap[7:0] == CRA_NO_REPLY;
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      op <= 8'h00;
      cnt <= 4'h0;
      ret_cap <= 24'h000000;
    end else if (req_hs && req_ctrl && req_data != CRA_TOK_END) begin
      op <= req_data;
      cnt <= 4'h0;
    end else if (req_hs && !req_ctrl) begin
      cnt <= cnt + 4'h1;
      if (cnt < 4'h3) ret_cap <= {ret_cap[15:0], req_data};
    end
  end
  // Data bytes are counted per reply so short or long reads show up
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rsp_bytes <= 3'h0;
      ack_read <= 1'b0;
    end else if (rsp_hs && rsp_ctrl) begin
      rsp_bytes <= 3'h0;
      ack_read <= rsp_data == CRA_TOK_ACK && op == CRA_TOK_READ;
    end else if (rsp_hs) begin
      rsp_bytes <= rsp_bytes + 3'h1;
    end
  end
  // ----------
  // Assertions
  // ----------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_req_held: assert property (req_valid && !req_ready |=> req_valid
    && $stable(req_data) && $stable(req_ctrl) && $stable(req_dest))
    else $error("request token changed before it was taken");
  a_rsp_held: assert property (rsp_valid && !rsp_ready |=> rsp_valid
    && $stable(rsp_data) && $stable(rsp_ctrl))
    else $error("reply token changed before it was taken");
  a_reply_head: assert property ($rose(rsp_valid) |-> rsp_ctrl
    && (rsp_data == CRA_TOK_ACK || rsp_data == CRA_TOK_NACK))
    else $error("reply does not open with success or failure token");
  a_nack_tail: assert property (rsp_hs && rsp_ctrl
    && rsp_data == CRA_TOK_NACK |=> rsp_valid && rsp_ctrl
    && rsp_data == CRA_TOK_END)
    else $error("failure token not followed by end token");
  a_read_bytes: assert property (rsp_hs && rsp_ctrl
    && rsp_data == CRA_TOK_END |-> rsp_bytes == (ack_read ? 3'h4 : 3'h0))
    else $error("reply carries wrong number of data bytes");
  a_req_fields: assert property (req_end |->
    (op == CRA_TOK_WRITE && cnt == 4'h9) || (op == CRA_TOK_READ
    && cnt == 4'h5))
    else $error("request has wrong number of field bytes");
  a_quiet_write: assert property (req_end && quiet |=>
    !rsp_valid [*8])
    else $error("reply sent for a write that asked for none");
  a_reply_due: assert property (req_end && !quiet |->
    ##[1:40] rsp_valid)
    else $error("no reply after request end");
  a_reply_dest: assert property ($rose(rsp_valid) |->
    rsp_dest == ret_cap)
    else $error("reply not aimed at captured return address");
  a_dest_form: assert property (req_valid |->
    req_dest[15:0] == CRA_DEST_TILE || req_dest[15:0] == CRA_DEST_NODE)
    else $error("request destination has a bad bank field");
endmodule : cra_link_monitor

// [test/test_config_register_access_msgs.sv]
// Testbench joining requester and device, plus a hand-driven second link
`timescale 1ns/1ps
module test_config_register_access_msgs import cra_pkg::*;;
  localparam logic [8:0] T_W = {1'b1, CRA_TOK_WRITE};
  localparam logic [8:0] T_R = {1'b1, CRA_TOK_READ};
  localparam logic [8:0] T_E = {1'b1, CRA_TOK_END};
  localparam logic [8:0] T_A = {1'b1, CRA_TOK_ACK};
  localparam logic [8:0] T_N = {1'b1, CRA_TOK_NACK};
  logic sys_clk_i = 1'b0, reset_n_i = 1'b0;
  logic cmd_valid_i = 1'b0, cmd_write_i = 1'b0, cmd_node_i = 1'b0;
  logic [15:0] cmd_id_i = 16'h0000, cmd_reg_i = 16'h0000;
  logic [23:0] cmd_ret_i = 24'h000000;
  logic [31:0] cmd_wdata_i = 32'h00000000, res_rdata_o, ps_res_o;
  logic cmd_ready_o, res_valid_o, res_ok_o, ps_done_o, ps_ok_o;
  logic [7:0] ps_num_i = 8'h02;
  logic ps_valid_i = 1'b0, ps_write_i = 1'b0, clk_div_en_o, clk_div_dyn_o;
  logic [31:0] ps_res_i = 32'h0, ps_wdata_i = 32'h0, ps_rdata_o;
  logic [255:0] tile_cfg_o, node_cfg_o;
  logic [8:0] rx_b[$];
  int num_errors = 0, check_count = 0, cycles = 0;
  cra_link_if link_a();
  cra_link_if link_b();
  cra_device u_cra_device (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .link(link_a), .ps_valid_i(ps_valid_i), .ps_write_i(ps_write_i),
    .ps_res_i(ps_res_i), .ps_wdata_i(ps_wdata_i), .ps_done_o(ps_done_o),
    .ps_ok_o(ps_ok_o), .ps_rdata_o(ps_rdata_o), .clk_div_en_o(clk_div_en_o),
    .clk_div_dyn_o(clk_div_dyn_o), .tile_cfg_o(tile_cfg_o),
    .node_cfg_o(node_cfg_o));
  cra_requester u_cra_requester (.sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i), .link(link_a), .cmd_valid_i(cmd_valid_i),
    .cmd_ready_o(cmd_ready_o), .cmd_write_i(cmd_write_i),
    .cmd_node_i(cmd_node_i), .cmd_id_i(cmd_id_i), .cmd_ret_i(cmd_ret_i),
    .cmd_reg_i(cmd_reg_i), .cmd_wdata_i(cmd_wdata_i),
    .res_valid_o(res_valid_o), .res_ok_o(res_ok_o),
    .res_rdata_o(res_rdata_o), .ps_num_i(ps_num_i), .ps_res_o(ps_res_o));
  // Second device faces the bench so malformed traffic can be injected
  cra_device u_cra_device_b (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .link(link_b), .ps_valid_i(1'b0), .ps_write_i(1'b0), .ps_res_i(32'h0),
    .ps_wdata_i(32'h0), .ps_done_o(), .ps_ok_o(), .ps_rdata_o(),
    .clk_div_en_o(), .clk_div_dyn_o(), .tile_cfg_o(), .node_cfg_o());
  cra_link_monitor u_cra_link_monitor (.sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i), .req_valid(link_a.req_valid),
    .req_ready(link_a.req_ready), .req_ctrl(link_a.req_ctrl),
    .req_data(link_a.req_data), .req_dest(link_a.req_dest),
    .rsp_valid(link_a.rsp_valid), .rsp_ready(link_a.rsp_ready),
    .rsp_ctrl(link_a.rsp_ctrl), .rsp_data(link_a.rsp_data),
    .rsp_dest(link_a.rsp_dest));
  // ----------
  // Clock, timeout and reply capture
  // ----------
  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      finish_test();
    end
    if (link_b.rsp_valid === 1'b1 && link_b.rsp_ready === 1'b1)
      rx_b.push_back({link_b.rsp_ctrl, link_b.rsp_data});
  end
  // ----------
  // Tasks
  // ----------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check
  task automatic do_cmd(input logic w, input logic n, input logic [15:0] id,
      input logic [23:0] ret, input logic [15:0] rg, input logic [31:0] wd,
      input logic ok, input logic [31:0] rd);
    int k;
    @(negedge sys_clk_i);
    for (k = 0; k < 100 && cmd_ready_o !== 1'b1; k++) @(negedge sys_clk_i);
    {cmd_write_i, cmd_node_i, cmd_id_i} = {w, n, id};
    {cmd_ret_i, cmd_reg_i, cmd_wdata_i} = {ret, rg, wd};
    cmd_valid_i = 1'b1;
    @(negedge sys_clk_i);
    cmd_valid_i = 1'b0;
    for (k = 0; k < 200 && res_valid_o !== 1'b1; k++) begin
      @(posedge sys_clk_i);
      #1;
    end
    check({31'h0, res_valid_o}, 32'h1);
    check({31'h0, res_ok_o}, {31'h0, ok});
    if (!w && ok) check(res_rdata_o, rd);
  endtask : do_cmd
  task automatic ps_acc(input logic w, input logic [31:0] res,
      input logic [31:0] wd, input logic ok, input logic [31:0] rd);
    @(negedge sys_clk_i);
    {ps_valid_i, ps_write_i, ps_res_i, ps_wdata_i} = {1'b1, w, res, wd};
    @(negedge sys_clk_i);
    ps_valid_i = 1'b0;
    check({30'h0, ps_done_o, ps_ok_o}, {30'h0, 1'b1, ok});
    if (!w) check(ps_rdata_o, rd);
  endtask : ps_acc
  task automatic send_seq(input logic [31:0] dest, input logic [8:0] s[$]);
    int k;
    foreach (s[i]) begin
      @(negedge sys_clk_i);
      {link_b.req_valid, link_b.req_dest} = {1'b1, dest};
      {link_b.req_ctrl, link_b.req_data} = s[i];
      for (k = 0; k < 50 && link_b.req_ready !== 1'b1; k++)
        @(negedge sys_clk_i);
      @(posedge sys_clk_i);
    end
    @(negedge sys_clk_i);
    link_b.req_valid = 1'b0;
  endtask : send_seq
  task automatic expect_rsp(input logic [8:0] e[$]);
    for (int k = 0; k < 100 && rx_b.size() < e.size(); k++)
      @(negedge sys_clk_i);
    check(rx_b.size(), e.size());
    foreach (e[i]) check({23'h0, rx_b[i]}, {23'h0, e[i]});
    rx_b.delete();
  endtask : expect_rsp
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  // ----------
  // Main sequence
  // ----------
  initial begin
    int n;
    {link_b.req_valid, link_b.req_ctrl, link_b.req_data} = 10'h0;
    link_b.req_dest = {16'h0001, CRA_DEST_TILE};
    link_b.rsp_ready = 1'b1;
    repeat (6) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    reset_n_i = 1'b1;
    check(ps_res_o, 32'h0000020C);
    do_cmd(1, 0, 16'h0001, 24'h001234, 16'h2, 32'hDEADBEEF, 1, 0);
    check(tile_cfg_o[64 +: 32], 32'hDEADBEEF);
    do_cmd(0, 0, 16'h0001, 24'h001234, 16'h2, 0, 1, 32'hDEADBEEF);
    for (int i = 0; i < 8; i++) begin
      do_cmd(1, 1, 16'h0001, 24'h000300, i[15:0], 32'hA5A50000 + i, 1, 0);
      check(node_cfg_o[32*i +: 32], 32'hA5A50000 + i);
    end
    do_cmd(0, 1, 16'h0001, 24'h000300, 16'h7, 0, 1, 32'hA5A50007);
    $display("test bank access done");
    do_cmd(1, 0, 16'h0001, 24'h000301, 16'h8, 32'h1, 0, 0);
    do_cmd(0, 1, 16'h0001, 24'h000301, 16'h8, 0, 0, 0);
    do_cmd(1, 0, 16'h0002, 24'h000301, 16'h2, 32'h1, 0, 0);
    check(tile_cfg_o[64 +: 32], 32'hDEADBEEF);
    do_cmd(1, 0, 16'h0001, 24'h0012FF, 16'h1, 32'h0BADF00D, 1, 0);
    // Quiet write lands a cycle after the requester reports it sent
    repeat (2) @(negedge sys_clk_i);
    check(tile_cfg_o[32 +: 32], 32'h0BADF00D);
    $display("test refusals done");
    ps_acc(0, 32'h0000000C, 0, 1, CRA_RAM_BASE_RST);
    ps_acc(1, 32'h0000020C, 32'hFFFFFFFF, 1, 0);
    check({30'h0, clk_div_dyn_o, clk_div_en_o}, 32'h3);
    ps_acc(0, 32'h0000020C, 0, 1, 32'h00000030);
    ps_acc(1, 32'h0000030C, 32'h1, 0, 0);
    ps_acc(0, 32'h0000020D, 0, 0, 0);
    ps_num_i = 8'h7F;
    #1 check(ps_res_o, 32'h00007F0C);
    $display("test status port done");
    send_seq({16'h0001, CRA_DEST_TILE}, '{T_R, 9'h0, 9'h1, 9'h0, 9'h0,
      9'h1F5, 9'h0, T_E});
    expect_rsp('{T_N, T_E});
    send_seq({16'h0001, CRA_DEST_TILE}, '{T_W, 9'h0, 9'h1, 9'h0, T_E});
    expect_rsp('{T_N, T_E});
    send_seq({16'h0001, 16'hC40C}, '{T_R, 9'h0, 9'h1, 9'h0, 9'h0, 9'h0,
      T_E});
    expect_rsp('{T_N, T_E});
    link_b.rsp_ready = 1'b0;
    send_seq({16'h0001, CRA_DEST_TILE}, '{T_W, 9'h0, 9'h1, 9'h0, 9'h0,
      9'h0, 9'h11, 9'h22, 9'h33, 9'h44, T_E});
    n = 0;
    for (int k = 0; k < 40; k++) begin
      @(negedge sys_clk_i);
      if (link_b.req_ready !== 1'b1) break;
      {link_b.req_valid, link_b.req_ctrl, link_b.req_data} = 10'h255;
      @(posedge sys_clk_i);
      n++;
    end
    link_b.req_valid = 1'b0;
    check(n, CRA_FIFO_DEPTH);
    link_b.rsp_ready = 1'b1;
    expect_rsp('{T_A, T_E});
    send_seq({16'h0001, CRA_DEST_TILE}, '{T_R, 9'h0, 9'h1, 9'h0, 9'h0,
      9'h0, T_E});
    expect_rsp('{T_A, 9'h11, 9'h22, 9'h33, 9'h44, T_E});
    $display("test second link done");
    finish_test();
  end
endmodule : test_config_register_access_msgs
